// file: hw/pubs_top.sv
// power-up boot sequencer: monitors, reset hold, clock defaults, cpu start
//
// Behaviour
// R01: enable both supply monitors first, before any other startup step.
// R02: hold internal reset until both monitors report supply above threshold.
// R03: select the system rc oscillator as system clock once supplies stable.
// R04: after power-up keep or disable each monitor per its fuse bit.
// R05: plls disabled at startup, stay off until software enables them.
// R06: every module clock gate open at startup.
// R07: all clock dividers pass-through at startup.
// R08: cpu fetches first instruction at 0x8000_0000 on reset release.
// R09: firmware should keep io supply monitor on during flash access.
// R10: software may enable plls, program dividers, gate unused clocks.
// R11: internal reset release synchronised to the rc oscillator clock.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module pubs_top (
  // clock and reset (clock is the rc oscillator)
  input  wire logic               clk_sys_in,
  input  wire logic               sys_rst_in,
  // supply monitor results, asynchronous
  input  wire logic               io_supply_ok_in,
  input  wire logic               core_supply_ok_in,
  // fuse bits, asynchronous straps
  input  wire pubs_pkg::pubs_fuse_t fuse_in,
  // register port
  input  wire logic [3:0]         reg_addr_in,
  input  wire logic [31:0]        reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic [31:0]             reg_rdata_out,
  // monitor enables
  output logic                    io_supply_monitor_en_out,
  output logic                    core_supply_monitor_en_out,
  // system reset and cpu start
  output logic                    core_rst_out,
  output logic                    cpu_start_out,
  output logic [31:0]             cpu_fetch_addr_out,
  // clock control
  output pubs_pkg::pubs_clk_t     clk_ctrl_out
);
  import pubs_pkg::*;

  //----------------------------------------------------------------
  // input synchronisers
  //----------------------------------------------------------------
  logic io_ok;
  logic core_ok;
  logic keep_io;
  logic keep_core;

  pubs_sync u_sync_io (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (io_supply_ok_in),
    .sync_out   (io_ok)
  );
  pubs_sync u_sync_core (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (core_supply_ok_in),
    .sync_out   (core_ok)
  );
  pubs_sync u_sync_fio (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (fuse_in.keep_io_mon),
    .sync_out   (keep_io)
  );
  pubs_sync u_sync_fcore (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (fuse_in.keep_core_mon),
    .sync_out   (keep_core)
  );

  //----------------------------------------------------------------
  // sequencer
  //----------------------------------------------------------------
  pubs_state_t state;
  pubs_state_t next_state;
  logic        next_io_mon;
  logic        next_core_mon;
  logic        next_rst;
  logic        next_start;
  logic        next_cfg_ld;
  logic        cfg_ld;

  // supplies are re-checked in every state after PUBS_ST_WAIT_SUPPLY: a dip on an enabled monitor drops back to reset
  always_comb begin
    next_state    = state;
    next_io_mon   = io_supply_monitor_en_out;
    next_core_mon = core_supply_monitor_en_out;
    next_rst      = core_rst_out;
    next_start    = 1'b0;
    next_cfg_ld   = 1'b0;
    case (state)
      PUBS_ST_MON_ON: begin
        next_io_mon   = 1'b1; // [R01]
        next_core_mon = 1'b1; // [R01]
        next_rst      = 1'b1;
        next_state    = PUBS_ST_WAIT_SUPPLY;
      end
      PUBS_ST_WAIT_SUPPLY: begin
        next_rst = 1'b1; // [R02]
        if (io_ok && core_ok) begin
          next_state = PUBS_ST_CLK_INIT;
        end
      end
      PUBS_ST_CLK_INIT: begin
        next_cfg_ld   = 1'b1; // [R03] [R05] [R06] [R07]
        next_io_mon   = keep_io; // [R04]
        next_core_mon = keep_core; // [R04]
        next_state    = PUBS_ST_RELEASE;
      end
      PUBS_ST_RELEASE: begin
        // release on a registered edge of the rc clock
        next_rst   = 1'b0; // [R11]
        next_start = 1'b1; // [R08]
        next_state = PUBS_ST_RUN;
      end
      PUBS_ST_RUN: begin
        next_rst = 1'b0;
      end
      default: begin
        next_state = PUBS_ST_MON_ON;
      end
    endcase
    // monitors only judge supplies while enabled; keep reset held on loss
    if (state != PUBS_ST_MON_ON && state != PUBS_ST_WAIT_SUPPLY &&
        ((io_supply_monitor_en_out && !io_ok) ||
         (core_supply_monitor_en_out && !core_ok))) begin
      next_state    = PUBS_ST_MON_ON; // [R02]
      next_rst      = 1'b1;
      next_start    = 1'b0;
      next_cfg_ld   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state                      <= PUBS_ST_MON_ON;
      io_supply_monitor_en_out   <= 1'b1;
      core_supply_monitor_en_out <= 1'b1;
      core_rst_out               <= 1'b1;
      cpu_start_out              <= 1'b0;
      cfg_ld                     <= 1'b0;
    end else begin
      state                      <= next_state;
      io_supply_monitor_en_out   <= next_io_mon;
      core_supply_monitor_en_out <= next_core_mon;
      core_rst_out               <= next_rst;
      cpu_start_out              <= next_start;
      cfg_ld                     <= next_cfg_ld;
    end
  end

  // fetch address is constant but registered so the output is a flop
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cpu_fetch_addr_out <= PUBS_RESET_ADDR; // [R08]
    end else begin
      cpu_fetch_addr_out <= PUBS_RESET_ADDR;
    end
  end

  //----------------------------------------------------------------
  // clock control registers
  //----------------------------------------------------------------
  pubs_clk_t next_clk;
  logic      sw_ok;

  // software writes ignored while the core is held in reset
  assign sw_ok = !core_rst_out && reg_wr_in;

  always_comb begin
    next_clk = clk_ctrl_out;
    if (cfg_ld) begin
      next_clk.clk_sel = PUBS_CLKSEL_RC; // [R03]
      next_clk.pll_en  = '0; // [R05]
      next_clk.gate_en = PUBS_GATE_RST; // [R06]
      next_clk.div     = PUBS_DIV_RST; // [R07]
    end else if (sw_ok) begin
      case (reg_addr_in)
        PUBS_REG_CLKCFG: begin
          next_clk.pll_en  = reg_wdata_in[PUBS_CFG_PLL_LSB +: PUBS_NUM_PLL]; // [R10]
          next_clk.clk_sel = reg_wdata_in[PUBS_CFG_SEL_LSB +: 2]; // [R10]
        end
        PUBS_REG_GATE: begin
          next_clk.gate_en = reg_wdata_in[PUBS_NUM_MOD-1:0]; // [R10]
        end
        PUBS_REG_DIV: begin
          next_clk.div = reg_wdata_in[PUBS_NUM_MOD*PUBS_DIV_W-1:0]; // [R10]
        end
        default: begin
          next_clk = clk_ctrl_out;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clk_ctrl_out.clk_sel <= PUBS_CLKSEL_RC;
      clk_ctrl_out.pll_en  <= '0;
      clk_ctrl_out.gate_en <= PUBS_GATE_RST;
      clk_ctrl_out.div     <= PUBS_DIV_RST;
    end else begin
      clk_ctrl_out <= next_clk;
    end
  end

  //----------------------------------------------------------------
  // read port, data one cycle after the strobe, zero otherwise
  //----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        PUBS_REG_CLKCFG: begin
          next_rdata[PUBS_CFG_PLL_LSB +: PUBS_NUM_PLL] = clk_ctrl_out.pll_en;
          next_rdata[PUBS_CFG_SEL_LSB +: 2]            = clk_ctrl_out.clk_sel;
        end
        PUBS_REG_GATE: next_rdata[PUBS_NUM_MOD-1:0] = clk_ctrl_out.gate_en;
        PUBS_REG_DIV:  next_rdata[PUBS_NUM_MOD*PUBS_DIV_W-1:0] = clk_ctrl_out.div;
        PUBS_REG_STATUS: begin
          next_rdata[0] = io_ok;
          next_rdata[1] = core_ok;
          next_rdata[2] = io_supply_monitor_en_out;
          next_rdata[3] = core_supply_monitor_en_out;
          next_rdata[4] = core_rst_out;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_init;
    state == PUBS_ST_CLK_INIT;
  endsequence
  sequence s_release;
    !core_rst_out && cpu_start_out;
  endsequence

  chk_mon_first: assert property ( // [R01]
    state == PUBS_ST_MON_ON |=> io_supply_monitor_en_out && core_supply_monitor_en_out)
    else $error("monitors not enabled first");
  chk_rst_held: assert property ( // [R02]
    ((io_supply_monitor_en_out && !io_ok) || (core_supply_monitor_en_out && !core_ok)) &&
      !core_rst_out |=> core_rst_out)
    else $error("reset not held on low supply");
  chk_clk_rc: assert property ( // [R03]
    s_init ##1 1 |=> clk_ctrl_out.clk_sel == PUBS_CLKSEL_RC)
    else $error("rc oscillator not selected");
  chk_fuse_keep: assert property ( // [R04]
    s_init |=> io_supply_monitor_en_out == $past(keep_io) &&
      core_supply_monitor_en_out == $past(keep_core))
    else $error("monitors not per fuse");
  chk_pll_off: assert property ( // [R05]
    cfg_ld |=> clk_ctrl_out.pll_en == '0)
    else $error("pll not off at startup");
  chk_gate_open: assert property ( // [R06]
    cfg_ld |=> clk_ctrl_out.gate_en == PUBS_GATE_RST)
    else $error("clock gates not open");
  chk_div_pass: assert property ( // [R07]
    cfg_ld |=> clk_ctrl_out.div == PUBS_DIV_RST)
    else $error("dividers not pass-through");
  chk_start_addr: assert property ( // [R08]
    s_release |-> cpu_fetch_addr_out == PUBS_RESET_ADDR && $past(core_rst_out))
    else $error("bad first fetch");
  chk_sw_pll: assert property ( // [R10]
    sw_ok && reg_addr_in == PUBS_REG_CLKCFG && !cfg_ld |=>
      clk_ctrl_out.pll_en == $past(reg_wdata_in[PUBS_NUM_PLL-1:0]))
    else $error("pll write lost");
  chk_rel_sync: assert property ( // [R11]
    $fell(core_rst_out) |-> $past(state) == PUBS_ST_RELEASE)
    else $error("reset released out of sequence");
endmodule // pubs_top

// file: hw/pubs_pkg.sv
// package: constants and carrier types for the power-up boot sequencer
package pubs_pkg;
  // clock source selection codes
  localparam logic [1:0] PUBS_CLKSEL_RC    = 2'h0;
  localparam logic [1:0] PUBS_CLKSEL_PLL0  = 2'h1;
  localparam logic [1:0] PUBS_CLKSEL_PLL1  = 2'h2;
  localparam logic [1:0] PUBS_CLKSEL_OSC   = 2'h3;
  // sizes
  localparam int         PUBS_NUM_PLL      = 2;
  localparam int         PUBS_NUM_MOD      = 8;
  localparam int         PUBS_DIV_W        = 3;
  // pass-through divider code
  localparam logic [2:0] PUBS_DIV_NONE     = 3'h0;
  // first fetch address, start of internal flash
  localparam logic [31:0] PUBS_RESET_ADDR  = 32'h8000_0000;
  // nominal rc oscillator rate
  localparam int         PUBS_RC_FREQ_HZ   = 115000;
  // reset release synchroniser depth
  localparam int         PUBS_SYNC_STAGES  = 2;
  // register map (word-aligned byte offsets)
  localparam logic [3:0] PUBS_REG_CLKCFG   = 4'h0;
  localparam logic [3:0] PUBS_REG_GATE     = 4'h4;
  localparam logic [3:0] PUBS_REG_DIV      = 4'h8;
  localparam logic [3:0] PUBS_REG_STATUS   = 4'hC;
  // clkcfg fields
  localparam int         PUBS_CFG_PLL_LSB  = 0;
  localparam int         PUBS_CFG_SEL_LSB  = 4;
  // reset values
  localparam logic [7:0] PUBS_GATE_RST     = 8'hFF;
  localparam logic [23:0] PUBS_DIV_RST     = 24'h000000;

  // clock control outputs travel together
  typedef struct packed {
    logic [1:0]                 clk_sel;
    logic [PUBS_NUM_PLL-1:0]    pll_en;
    logic [PUBS_NUM_MOD-1:0]    gate_en;
    logic [PUBS_NUM_MOD*PUBS_DIV_W-1:0] div;
  } pubs_clk_t;

  // fuse bits for monitor keep-alive
  typedef struct packed {
    logic keep_io_mon;
    logic keep_core_mon;
  } pubs_fuse_t;

  typedef enum logic [2:0] {
    PUBS_ST_MON_ON,
    PUBS_ST_WAIT_SUPPLY,
    PUBS_ST_CLK_INIT,
    PUBS_ST_RELEASE,
    PUBS_ST_RUN
  } pubs_state_t;
endpackage

// file: hw/pubs_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module pubs_sync (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  // data
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync;

  // first stage feeds only the second
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule // pubs_sync

// file: tb/pubs_supply_model.sv
// supply monitor model: reports the commanded supply only while enabled
`timescale 1ns/1ps
module pubs_supply_model (
  // clock
  input  wire logic clk_sys_in,
  // supply levels set by the bench
  input  wire logic io_up_in,
  input  wire logic core_up_in,
  // monitor enables from the sequencer
  input  wire logic io_en_in,
  input  wire logic core_en_in,
  // monitor results
  output logic      io_ok_out,
  output logic      core_ok_out
);
  // ----------------------------------------
  // monitor outputs
  // ----------------------------------------
  logic flip;
  initial flip = 1'b0;
  // a switched-off monitor says nothing useful, so its output wanders
  always @(posedge clk_sys_in) begin
    flip <= ~flip;
  end
  assign io_ok_out   = io_en_in ? io_up_in : flip;
  assign core_ok_out = core_en_in ? core_up_in : ~flip;
endmodule // pubs_supply_model

// file: tb/pubs_top_bench.sv
// bench for the power-up boot sequencer: boot order, defaults, fuses, registers
`timescale 1ns/1ps
module pubs_top_bench;
  import pubs_pkg::*;
  logic clk_sys_in, sys_rst_in, io_up, core_up, io_ok, core_ok;
  logic reg_wr, reg_rd, io_en, core_en, core_rst, cpu_start;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fetch_addr, v;
  pubs_fuse_t fuse;
  pubs_clk_t clk_ctrl;
  int failures, samples_checked;
  // ----------------------------------------
  // clock, design and supply model
  // ----------------------------------------
  initial clk_sys_in = 1'b0;
  always #25 clk_sys_in = ~clk_sys_in;
  pubs_top u_pubs_top (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .io_supply_ok_in(io_ok), .core_supply_ok_in(core_ok), .fuse_in(fuse),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .io_supply_monitor_en_out(io_en),
    .core_supply_monitor_en_out(core_en), .core_rst_out(core_rst),
    .cpu_start_out(cpu_start), .cpu_fetch_addr_out(fetch_addr), .clk_ctrl_out(clk_ctrl));
  pubs_supply_model u_pubs_supply_model (.clk_sys_in(clk_sys_in), .io_up_in(io_up),
    .core_up_in(core_up), .io_en_in(io_en), .core_en_in(core_en),
    .io_ok_out(io_ok), .core_ok_out(core_ok));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait: 0 for the start pulse, 1 for reset asserted
  task automatic wait_for(input int which);
    int n;
    n = 0;
    while (((which == 0) ? cpu_start : core_rst) !== 1'b1) begin
      @(posedge clk_sys_in);
      #1 n++;
      if (n > 200) begin
        failures++;
        $display("Error wait expected 1 seen 0");
        close_out();
      end
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic chk_dflt();
    chk("clk_sel", PUBS_CLKSEL_RC, clk_ctrl.clk_sel);
    chk("pll_en", 32'h0, clk_ctrl.pll_en);
    chk("gate_en", PUBS_GATE_RST, clk_ctrl.gate_en);
    chk("div", PUBS_DIV_RST, clk_ctrl.div);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    samples_checked = 0;
    sys_rst_in = 1'b1;
    io_up = 1'b0;
    core_up = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    fuse = '{keep_io_mon: 1'b1, keep_core_mon: 1'b0}; // io monitor kept for flash
    idle(11);
    chk_dflt();
    // release on a rising edge, so reset spans twelve cycles
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    idle(20);
    chk("io_en", 32'h1, io_en);
    chk("core_en", 32'h1, core_en);
    chk("rst_none", 32'h1, core_rst);
    wr(PUBS_REG_CLKCFG, 32'h13);      // refused while held in reset
    rd(PUBS_REG_CLKCFG, v);
    chk("cfg_in_rst", 32'h0, v);
    io_up <= 1'b1;
    idle(20);
    chk("rst_io_only", 32'h1, core_rst);
    core_up <= 1'b1;
    wait_for(0);
    chk("rst_rel", 32'h0, core_rst);
    chk("fetch", PUBS_RESET_ADDR, fetch_addr);
    chk_dflt();
    idle(1);
    chk("start_pulse", 32'h0, cpu_start);
    chk("io_keep", 32'h1, io_en);
    chk("core_off", 32'h0, core_en);
    // software reconfigures clocks, one write after another
    wr(PUBS_REG_CLKCFG, 32'h13);
    wr(PUBS_REG_GATE, 32'h0F);
    wr(PUBS_REG_DIV, 32'h00FAC688);
    chk("pll_sw", 32'h3, clk_ctrl.pll_en);
    chk("sel_sw", PUBS_CLKSEL_PLL0, clk_ctrl.clk_sel);
    chk("gate_sw", 32'h0F, clk_ctrl.gate_en);
    chk("div_sw", 32'hFAC688, clk_ctrl.div);
    rd(PUBS_REG_GATE, v);
    chk("gate_rd", 32'h0F, v);
    rd(4'h2, v);
    chk("unmapped", 32'h0, v);
    rd(PUBS_REG_STATUS, v);
    chk("status", 32'h05, v & 32'h1D);
    // a switched-off core monitor no longer resets the chip
    core_up <= 1'b0;
    idle(20);
    chk("core_ignored", 32'h0, core_rst);
    core_up <= 1'b1;
    io_up <= 1'b0;
    wait_for(1);
    idle(4);
    chk("rst_loss", 32'h1, core_rst);
    chk("core_reon", 32'h1, core_en);
    io_up <= 1'b1;
    wait_for(0);
    chk_dflt();
    // second power-on reset with the other fuse setting, edge aligned
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    fuse <= '{keep_io_mon: 1'b0, keep_core_mon: 1'b1};
    idle(11);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wait_for(0);
    idle(1);
    chk("io_off", 32'h0, io_en);
    chk("core_keep", 32'h1, core_en);
    close_out();
  end
endmodule // pubs_top_bench
